// ===== include/i2c_seq_pkg.sv
package i2c_seq_pkg;

   // ----------------------------------------------------------------
   // bit positions in the control and status words
   // ----------------------------------------------------------------
   localparam int START_EN_BIT = 0;
   localparam int RSTART_EN_BIT = 1;
   localparam int ACK_STAT_BIT = 6;
   localparam int BUF_FULL_BIT = 0;
   localparam int START_DET_BIT = 3;
   localparam int CTRL_LOCK_W = 5;

   // ----------------------------------------------------------------
   // widths, reset values and timing
   // ----------------------------------------------------------------
   localparam int RELOAD_W = 7;
   localparam logic [7:0] BUF_RST = 8'h00;
   localparam logic [6:0] RELOAD_RST = 7'h7F;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam int SYS_PERIOD_NS = 40;
   localparam int WRITE_COLLISION_FLAG_WIN_NS = 80;
   localparam logic [1:0] WRITE_COLLISION_FLAG_WIN_CYC =
      2'((WRITE_COLLISION_FLAG_WIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
   // sda, scl, sleep: lines idle high, sleep idle low
   localparam logic [2:0] PIN_RST = 3'h3;

   // ----------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [10:0] {
      IDLE   = 11'h001,
      S_WAIT = 11'h002,
      S_HOLD = 11'h004,
      R_LOW  = 11'h008,
      R_SDAH = 11'h010,
      R_ARB  = 11'h020,
      R_HIGH = 11'h040,
      R_SDAL = 11'h080,
      T_LOW  = 11'h100,
      T_ARB  = 11'h200,
      T_HIGH = 11'h400
   } seq_state_t;

endpackage

// ===== logic/i2c_master_bus_sequencer.sv
`timescale 1ns/1ps
// Summary of operation
// - counter does not count down while sleep is asserted
// - serial clock period equals two counter rollovers
// - counter waits until scl seen high, reloads
// - start checks both lines high, then counts
// - timeout with lines high drives sda low
// - second period ends start, clears enable
// - low line during start aborts with collision
// - buffer write during start sets collision flag
// - control writes blocked until start completes
// - repeated start pulls scl low, releases sda
// - release scl, count, drive sda low, finish
// - start flag at condition, interrupt at timeout
// - repeated start ignored while anything busy
// - repeated start collision on bad sda/scl
// - writes blocked during repeated start
// - buffer write sets full flag, starts byte
// - bit driven after scl falls, low/high rollovers
// - eighth fall clears full flag, releases sda
// - ninth fall samples sda into ack status
// - after ninth clock interrupt, scl held low
// - busy write flags collision, rewrite window updates
// - write collision flag cleared only by software
// - counter reloads low seven bits, counts down
module i2c_master_bus_sequencer
   import i2c_seq_pkg::*;
(
   // system side
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic link_clk_in,
   input wire logic sleep_in,
   // software control
   input wire logic ctrl_wr_in,
   input wire logic [7:0] ctrl_wdata_in,
   input wire logic tx_write_in,
   input wire logic [7:0] tx_data_in,
   input wire logic [7:0] reload_in,
   input wire logic write_collision_flag_clear_in,
   input wire logic bcol_clear_in,
   input wire logic irq_clear_in,
   input wire logic start_det_clear_in,
   // software status
   output logic [7:0] ctrl_out,
   output logic [7:0] status_out,
   output logic write_collision_out,
   output logic bus_collision_out,
   output logic port_irq_out,
   // two-wire bus
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_out
);

   // ----------------------------------------------------------------
   // system domain state
   // ----------------------------------------------------------------
   logic busy_r, buf_full_r, wr_col_r, start_det_r, bus_col_r, irq_r, ack_stat_r;
   logic st_en_r, rs_en_r;
   logic [7:0] buf_r;
   logic [6:0] reload_r;
   logic [1:0] win_r;
   logic [2:0] cmd_t_r;
   logic [2:0] lk_s1_r, lk_s2_r, lk_s3_r;

   // link domain state
   logic [1:0] lrst_r;
   logic lrst_n;
   logic [2:0] pin_s1_r, pin_s2_r, pin_s3_r, filt_r;
   logic [2:0] cmd_s1_r, cmd_s2_r, cmd_s3_r;
   seq_state_t st_r, st_nxt;
   logic [RELOAD_W-1:0] baud_cnt_r;
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic sda_lo_r, sda_nxt, scl_lo_r, scl_nxt;
   logic col_r, ack_r, ack_nxt;
   logic done_t_r, sdt_t_r, bfc_t_r;
   logic load, fin, fcol, fsdt, fbfc;

   // ----------------------------------------------------------------
   // software decode
   // ----------------------------------------------------------------
   wire st_go = ctrl_wr_in && ctrl_wdata_in[START_EN_BIT] && !busy_r;
   wire rs_go = ctrl_wr_in && ctrl_wdata_in[RSTART_EN_BIT] && !busy_r
                && !ctrl_wdata_in[START_EN_BIT];
   wire tx_go = tx_write_in && !busy_r && !ctrl_wr_in;
   wire tx_col = tx_write_in && !tx_go;
   // a rewrite just after an accepted write still lands; the link has
   // not taken the buffer yet, so the byte sent is the rewritten value
   wire buf_upd = tx_go || (tx_col && win_r != 2'h0);
   wire any_go = st_go || rs_go || tx_go;
   wire [2:0] lk_ev = lk_s2_r ^ lk_s3_r;
   wire done_ev = lk_ev[0];
   wire sdt_ev = lk_ev[1];
   wire bfc_ev = lk_ev[2];

   assign ctrl_out = (8'(st_en_r) << START_EN_BIT) | (8'(rs_en_r) << RSTART_EN_BIT)
                     | (8'(ack_stat_r) << ACK_STAT_BIT);
   assign status_out = (8'(buf_full_r) << BUF_FULL_BIT)
                       | (8'(start_det_r) << START_DET_BIT);
   assign write_collision_out = wr_col_r;
   assign bus_collision_out = bus_col_r;
   assign port_irq_out = irq_r;

   // ----------------------------------------------------------------
   // system domain registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         busy_r <= 1'b0;
         st_en_r <= 1'b0;
         rs_en_r <= 1'b0;
         cmd_t_r <= 3'h0;
         buf_r <= BUF_RST;
         reload_r <= RELOAD_RST;
         win_r <= 2'h0;
      end else begin
         busy_r <= any_go || (busy_r && !done_ev);
         st_en_r <= st_go || (st_en_r && !done_ev);
         rs_en_r <= rs_go || (rs_en_r && !done_ev);
         cmd_t_r <= cmd_t_r ^ {tx_go, rs_go, st_go};
         if (buf_upd) buf_r <= tx_data_in;
         if (any_go) reload_r <= reload_in[RELOAD_W-1:0];
         win_r <= tx_go ? WRITE_COLLISION_FLAG_WIN_CYC : (win_r != 2'h0 ? win_r - 2'h1 : 2'h0);
      end
   end

   // event flags: a set in the same cycle as a clear wins
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         buf_full_r <= 1'b0;
         wr_col_r <= 1'b0;
         start_det_r <= 1'b0;
         bus_col_r <= 1'b0;
         irq_r <= 1'b0;
         ack_stat_r <= 1'b0;
      end else begin
         buf_full_r <= tx_go || (buf_full_r && !bfc_ev && !(done_ev && col_r));
         wr_col_r <= tx_col || (wr_col_r && !write_collision_flag_clear_in);
         start_det_r <= sdt_ev || (start_det_r && !start_det_clear_in);
         bus_col_r <= (done_ev && col_r) || (bus_col_r && !bcol_clear_in);
         irq_r <= (done_ev && !col_r) || (irq_r && !irq_clear_in);
         if (done_ev && !col_r) ack_stat_r <= ack_r;
      end
   end

   // link toggles into the system domain; held clear in reset so that
   // toggles dropped back to zero by the link reset raise no false event
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         lk_s1_r <= 3'h0;
         lk_s2_r <= 3'h0;
         lk_s3_r <= 3'h0;
      end else begin
         lk_s1_r <= {bfc_t_r, sdt_t_r, done_t_r};
         lk_s2_r <= lk_s1_r;
         lk_s3_r <= lk_s2_r;
      end
   end

   // ----------------------------------------------------------------
   // link domain input conditioning
   // ----------------------------------------------------------------
   always_ff @(posedge link_clk_in) begin
      lrst_r <= {lrst_r[0], resetn_in};
      cmd_s1_r <= cmd_t_r;
      cmd_s2_r <= cmd_s1_r;
      cmd_s3_r <= cmd_s2_r;
   end
   assign lrst_n = lrst_r[1];
   wire [2:0] cmd_ev = cmd_s2_r ^ cmd_s3_r;

   // bus lines and sleep are asynchronous; a change counts only once
   // the second and third stages agree, which rejects single glitches
   wire [2:0] pins = {sleep_in, scl_in, sda_in};
   for (genvar i = 0; i < 3; i++) begin : g_pin
      always_ff @(posedge link_clk_in) begin
         pin_s1_r[i] <= pins[i];
         pin_s2_r[i] <= pin_s1_r[i];
         pin_s3_r[i] <= pin_s2_r[i];
         if (!lrst_n) filt_r[i] <= PIN_RST[i];
         else if (pin_s2_r[i] == pin_s3_r[i]) filt_r[i] <= pin_s3_r[i];
      end
   end
   wire sda_f = filt_r[0];
   wire scl_f = filt_r[1];
   wire sleep_f = filt_r[2];

   // ----------------------------------------------------------------
   // baud counter
   // ----------------------------------------------------------------
   wire tmo = (baud_cnt_r == '0) && !sleep_f;
   always_ff @(posedge link_clk_in) begin
      if (!lrst_n) baud_cnt_r <= '0;
      else if (load) baud_cnt_r <= reload_r;
      else if (baud_cnt_r != '0 && !sleep_f) baud_cnt_r <= baud_cnt_r - 1'b1;
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      load = 1'b0;
      sda_nxt = sda_lo_r;
      scl_nxt = scl_lo_r;
      fin = 1'b0;
      fcol = 1'b0;
      fsdt = 1'b0;
      fbfc = 1'b0;
      ack_nxt = ack_r;
      sh_nxt = sh_r;
      cnt_nxt = cnt_r;
      unique case (st_r)
         IDLE: begin
            if (cmd_ev[0]) begin
               if (sda_f && scl_f) begin
                  load = 1'b1;
                  st_nxt = S_WAIT;
               end else fcol = 1'b1;
            end else if (cmd_ev[1]) begin
               scl_nxt = 1'b1;
               st_nxt = R_LOW;
            end else if (cmd_ev[2]) begin
               sh_nxt = buf_r;
               cnt_nxt = 4'h0;
               scl_nxt = 1'b1;
               load = 1'b1;
               st_nxt = T_LOW;
            end
         end
         S_WAIT: begin
            if (!scl_f) fcol = 1'b1;
            else if (tmo) begin
               if (sda_f) begin
                  sda_nxt = 1'b1;
                  fsdt = 1'b1;
                  load = 1'b1;
                  st_nxt = S_HOLD;
               end else fcol = 1'b1;
            end
         end
         S_HOLD: begin
            if (tmo) begin
               fin = 1'b1;
               st_nxt = IDLE;
            end
         end
         R_LOW: begin
            if (!scl_f) begin
               sda_nxt = 1'b0;
               load = 1'b1;
               st_nxt = R_SDAH;
            end
         end
         R_SDAH: begin
            if (tmo && sda_f) begin
               scl_nxt = 1'b0;
               st_nxt = R_ARB;
            end else if (tmo) fcol = 1'b1;
         end
         R_ARB: begin
            if (scl_f && !sda_f) fcol = 1'b1;
            else if (scl_f) begin
               load = 1'b1;
               st_nxt = R_HIGH;
            end
         end
         R_HIGH: begin
            if (!scl_f) fcol = 1'b1;
            else if (tmo) begin
               sda_nxt = 1'b1;
               fsdt = 1'b1;
               load = 1'b1;
               st_nxt = R_SDAL;
            end
         end
         R_SDAL: begin
            if (tmo) begin
               fin = 1'b1;
               st_nxt = IDLE;
            end
         end
         T_LOW: begin
            // data moves one link cycle after scl falls, never on the same
            // edge, so a target cannot mistake a bit change for a start
            sda_nxt = (cnt_r == ACK_BIT) ? 1'b0 : !sh_r[7];
            if (tmo) begin
               scl_nxt = 1'b0;
               st_nxt = T_ARB;
            end
         end
         T_ARB: begin
            if (scl_f) begin
               load = 1'b1;
               st_nxt = T_HIGH;
            end
         end
         T_HIGH: begin
            if (tmo) begin
               scl_nxt = 1'b1;
               cnt_nxt = cnt_r + 4'h1;
               if (cnt_r == ACK_BIT) begin
                  ack_nxt = sda_f;
                  fin = 1'b1;
                  st_nxt = IDLE;
               end else begin
                  if (cnt_r == LAST_DATA_BIT) fbfc = 1'b1;
                  else sh_nxt = {sh_r[6:0], 1'b0};
                  load = 1'b1;
                  st_nxt = T_LOW;
               end
            end
         end
         default: st_nxt = IDLE;
      endcase
      if (fcol) begin
         sda_nxt = 1'b0;
         scl_nxt = 1'b0;
         fin = 1'b1;
         st_nxt = IDLE;
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (!lrst_n) begin
         st_r <= IDLE;
         cnt_r <= 4'h0;
         sh_r <= BUF_RST;
         sda_lo_r <= 1'b0;
         scl_lo_r <= 1'b0;
         col_r <= 1'b0;
         ack_r <= 1'b0;
         done_t_r <= 1'b0;
         sdt_t_r <= 1'b0;
         bfc_t_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         sda_lo_r <= sda_nxt;
         scl_lo_r <= scl_nxt;
         if (fin) col_r <= fcol;
         ack_r <= ack_nxt;
         done_t_r <= done_t_r ^ fin;
         sdt_t_r <= sdt_t_r ^ fsdt;
         bfc_t_r <= bfc_t_r ^ fbfc;
      end
   end

   // open drain: drive low only while enabled
   assign sda_out = 1'b0;
   assign scl_out = 1'b0;
   assign sda_oe_out = sda_lo_r;
   assign scl_oe_out = scl_lo_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence start_launch;
      st_r == S_WAIT && scl_f && sda_f && tmo;
   endsequence
   sequence start_drive;
      sda_lo_r && !scl_lo_r && st_r == S_HOLD && sdt_t_r != $past(sdt_t_r);
   endsequence

   sleep_freeze_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
      sleep_f && !load |=> baud_cnt_r == $past(baud_cnt_r))
      else $error("baud counter moved during sleep");
   count_down_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
      !load && !sleep_f && baud_cnt_r != '0 |=> baud_cnt_r == $past(baud_cnt_r) - 1'b1)
      else $error("baud counter did not decrement");
   arb_pause_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
      st_r == T_ARB && !scl_f |=> st_r == T_ARB && baud_cnt_r == '0)
      else $error("counter ran while scl held low");
   start_drive_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
      start_launch |=> start_drive)
      else $error("start condition not driven");
   start_col_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
      st_r == S_WAIT && !scl_f |=> st_r == IDLE && col_r && !sda_lo_r && !scl_lo_r)
      else $error("start collision not taken");
   rs_col_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
      st_r == R_ARB && scl_f && !sda_f |=> st_r == IDLE && col_r && !scl_lo_r)
      else $error("repeated start collision missed");
   ack_stat_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
      st_r == T_HIGH && tmo && cnt_r == ACK_BIT |=> ack_r == $past(sda_f) && scl_lo_r)
      else $error("acknowledge not sampled");
   eighth_fall_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
      st_r == T_HIGH && tmo && cnt_r == LAST_DATA_BIT
      |=> bfc_t_r != $past(bfc_t_r) ##1 !sda_lo_r)
      else $error("sda not released at eighth fall");
   data_hold_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
      st_r == T_HIGH && tmo |=> sda_lo_r == $past(sda_lo_r) && scl_lo_r)
      else $error("sda changed on the scl falling edge");
   write_collision_flag_set_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      tx_write_in && busy_r && win_r == 2'h0 |=> wr_col_r && buf_r == $past(buf_r))
      else $error("blocked buffer write changed buffer");
   write_collision_flag_sticky_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      wr_col_r && !write_collision_flag_clear_in |=> wr_col_r)
      else $error("write collision cleared by hardware");
   rs_ignore_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      ctrl_wr_in && busy_r |=> cmd_t_r[1:0] == $past(cmd_t_r[1:0]))
      else $error("control write accepted while busy");
   bf_set_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      tx_go |=> buf_full_r && busy_r)
      else $error("buffer write did not start a byte");

endmodule

// ===== verification/i2c_slave_model.sv
`timescale 1ns/1ps
// addressed target on the two-wire bus: acks the ninth bit, can stretch
// the low phase of scl and can pin sda low to provoke a collision
module i2c_slave_model (
   // bus
   input wire logic sda_in,
   input wire logic scl_in,
   output logic sda_oe_out,
   output logic scl_oe_out,
   // test control
   input wire logic ack_en_in,
   input wire logic stretch_en_in,
   input wire logic sda_hold_in,
   output logic [7:0] rx_byte_out
);
   logic ack_drv = 1'b0;
   logic [7:0] shift_r = 8'h00;
   int nfall = 0;

   initial begin
      scl_oe_out = 1'b0;
      rx_byte_out = 8'h00;
   end
   // released lines float to the pull-up level
   assign sda_oe_out = ack_drv | sda_hold_in;

   // a start re-arms the bit count; first fall after it carries no data
   always @(negedge sda_in) begin
      if (scl_in === 1'b1) begin
         nfall = -1;
         ack_drv = 1'b0;
      end
   end

   always @(posedge scl_in) begin
      shift_r = {shift_r[6:0], sda_in};
   end

   always @(negedge scl_in) begin
      nfall++;
      if (nfall == 8) begin
         rx_byte_out = shift_r;
         ack_drv = ack_en_in;
      end else if (nfall == 9) begin
         ack_drv = 1'b0;
         nfall = 0;
      end
      // hold scl low longer than the master's low phase
      if (stretch_en_in) begin
         scl_oe_out = 1'b1;
         #700;
         scl_oe_out = 1'b0;
      end
   end
endmodule

// ===== verification/i2c_master_bus_sequencer_test.sv
`timescale 1ns/1ps
module i2c_master_bus_sequencer_test
   import i2c_seq_pkg::*;
;
   logic sys_clk = 1'b0, link_clk = 1'b0, resetn = 1'b0, sleep = 1'b0;
   logic ctrl_wr = 1'b0, tx_wr = 1'b0, clr = 1'b0;
   logic [7:0] ctrl_wd = 8'h00, tx_d = 8'h00, reload = 8'h04;
   logic ack_en = 1'b1, stretch = 1'b0, sda_hold = 1'b0, mon_en = 1'b0, rise_ok = 1'b0;
   wire logic [7:0] ctrl_o, stat_o, rx;
   wire logic write_collision_flag, bcol, irq, sda_oe, scl_oe, s_sda_oe, s_scl_oe;
   wire logic sda_line = !(sda_oe | s_sda_oe);
   wire logic scl_line = !(scl_oe | s_scl_oe);
   int fails = 0, n_tests = 0;
   realtime t_rise;

   always #20 sys_clk = ~sys_clk;
   initial begin
      #7;
      forever #24 link_clk = ~link_clk;
   end

   i2c_master_bus_sequencer i2c_master_bus_sequencer_inst (
      .sys_clk_in(sys_clk), .resetn_in(resetn), .link_clk_in(link_clk),
      .sleep_in(sleep), .ctrl_wr_in(ctrl_wr), .ctrl_wdata_in(ctrl_wd),
      .tx_write_in(tx_wr), .tx_data_in(tx_d), .reload_in(reload),
      .write_collision_flag_clear_in(clr), .bcol_clear_in(clr), .irq_clear_in(clr),
      .start_det_clear_in(clr), .ctrl_out(ctrl_o), .status_out(stat_o),
      .write_collision_out(write_collision_flag), .bus_collision_out(bcol), .port_irq_out(irq),
      .sda_in(sda_line), .sda_out(), .sda_oe_out(sda_oe),
      .scl_in(scl_line), .scl_out(), .scl_oe_out(scl_oe));

   i2c_slave_model i2c_slave_model_inst (
      .sda_in(sda_line), .scl_in(scl_line), .sda_oe_out(s_sda_oe),
      .scl_oe_out(s_scl_oe), .ack_en_in(ack_en), .stretch_en_in(stretch),
      .sda_hold_in(sda_hold), .rx_byte_out(rx));

   // ----------------------------------------------------------------
   // common tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // scl high phase: at least one period after the line is seen high
   always @(posedge scl_line) begin
      t_rise = $realtime;
      rise_ok = mon_en;
   end
   always @(negedge scl_line) begin
      if (rise_ok) begin
         check("scl_high_min", 8'($realtime - t_rise >= (reload[6:0] + 1) * 48), 8'h01);
         check("scl_high_max", 8'($realtime - t_rise <= (reload[6:0] + 9) * 48), 8'h01);
      end
      rise_ok = 1'b0;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // sel 0 waits for the interrupt flag, 1 for the collision flag
   task automatic wait_for(input int sel, input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         @(posedge sys_clk);
         #1;
         if ((sel == 0 && irq === 1'b1) || (sel == 1 && bcol === 1'b1)) break;
      end
      if (i == lim) begin
         fails++;
         $display("CHECK FAILED wait_%0d expected 1 seen 0", sel);
         final_report();
      end
   endtask

   task automatic wr_ctrl(input logic [7:0] d);
      @(posedge sys_clk);
      ctrl_wr <= 1'b1;
      ctrl_wd <= d;
      @(posedge sys_clk);
      ctrl_wr <= 1'b0;
      #1;
   endtask

   task automatic wr_tx(input logic [7:0] d);
      @(posedge sys_clk);
      tx_wr <= 1'b1;
      tx_d <= d;
      @(posedge sys_clk);
      tx_wr <= 1'b0;
      #1;
   endtask

   task automatic clear_flags();
      @(posedge sys_clk);
      clr <= 1'b1;
      @(posedge sys_clk);
      clr <= 1'b0;
      cyc(1);
   endtask

   task automatic do_reset();
      @(posedge sys_clk);
      resetn <= 1'b0;
      sda_hold <= 1'b0;
      cyc(5);
      resetn <= 1'b1;
      cyc(10);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_start(input logic asleep, input logic line_low);
      sda_hold <= line_low;
      sleep <= asleep;
      wr_ctrl(8'h01);
      check("start_en", ctrl_o[START_EN_BIT], 8'h01);
      wr_tx(8'h11);
      wr_ctrl(8'h02);
      check("start_write_collision_flag", write_collision_flag, 8'h01);
      check("start_lock", ctrl_o[RSTART_EN_BIT], 8'h00);
      if (asleep) begin
         cyc(300);
         check("sleep_irq", irq, 8'h00);
         check("sleep_sda", sda_oe, 8'h00);
         sleep <= 1'b0;
      end
      if (line_low) begin
         wait_for(1, 500);
         cyc(2);
         check("bc_lines", {sda_oe, scl_oe}, 8'h00);
         check("bc_en", ctrl_o[START_EN_BIT], 8'h00);
         check("bc_irq", irq, 8'h00);
      end else begin
         wait_for(0, 2000);
         check("s_lines", {sda_oe, scl_oe}, 8'h02);
         check("s_det", stat_o[START_DET_BIT], 8'h01);
         check("s_en", ctrl_o[START_EN_BIT], 8'h00);
         check("s_bf", stat_o[BUF_FULL_BIT], 8'h00);
         check("s_bcol", bcol, 8'h00);
      end
      clear_flags();
   endtask

   // gap 0: single write, 1: rewrite next cycle, else late write after gap
   task automatic t_byte(input logic [7:0] d, input logic ack, input int gap,
                         input logic [7:0] d2, input logic [7:0] exp);
      ack_en <= ack;
      mon_en <= 1'b1;
      if (gap == 1) begin
         @(posedge sys_clk);
         tx_wr <= 1'b1;
         tx_d <= d;
         @(posedge sys_clk);
         tx_d <= d2;
         @(posedge sys_clk);
         tx_wr <= 1'b0;
         #1;
      end else begin
         wr_tx(d);
      end
      check("bf_set", stat_o[BUF_FULL_BIT], 8'h01);
      if (gap > 1) begin
         cyc(gap);
         wr_tx(d2);
         wr_ctrl(8'h02);
         check("rs_busy", ctrl_o[RSTART_EN_BIT], 8'h00);
      end
      wait_for(0, 4000);
      mon_en <= 1'b0;
      check("rx_byte", rx, exp);
      check("ack_stat", ctrl_o[ACK_STAT_BIT], 8'(!ack));
      check("bf_clr", stat_o[BUF_FULL_BIT], 8'h00);
      check("hold_lines", {sda_oe, scl_oe}, 8'h01);
      check("write_collision_flag_keep", write_collision_flag, 8'(gap != 0));
      cyc(40);
      check("write_collision_flag_stay", write_collision_flag, 8'(gap != 0));
      clear_flags();
      check("write_collision_flag_swclr", write_collision_flag, 8'h00);
   endtask

   task automatic t_rstart(input logic line_low);
      sda_hold <= line_low;
      wr_ctrl(8'h02);
      check("rs_en", ctrl_o[RSTART_EN_BIT], 8'h01);
      wr_tx(8'h3C);
      wr_ctrl(8'h01);
      check("rs_write_collision_flag", write_collision_flag, 8'h01);
      check("rs_lock", ctrl_o[START_EN_BIT], 8'h00);
      if (line_low) begin
         wait_for(1, 1000);
         cyc(2);
         check("rbc_lines", {sda_oe, scl_oe}, 8'h00);
         check("rbc_en", ctrl_o[RSTART_EN_BIT], 8'h00);
         check("rbc_irq", irq, 8'h00);
      end else begin
         wait_for(0, 2000);
         check("rs_det", stat_o[START_DET_BIT], 8'h01);
         check("rs_lines", {sda_oe, scl_oe}, 8'h02);
         check("rs_done", ctrl_o[RSTART_EN_BIT], 8'h00);
         check("rs_bf", stat_o[BUF_FULL_BIT], 8'h00);
         check("rs_bcol", bcol, 8'h00);
      end
      clear_flags();
   endtask

   initial begin
      reload <= 8'h04;
      do_reset();
      t_start(1'b1, 1'b0);
      t_byte(8'hA5, 1'b1, 0, 8'h00, 8'hA5);
      t_byte(8'h5A, 1'b0, 20, 8'hC3, 8'h5A);
      t_rstart(1'b0);
      reload <= 8'h09;
      stretch <= 1'b1;
      t_byte(8'h96, 1'b1, 1, 8'h3B, 8'h3B);
      stretch <= 1'b0;
      cyc(40);
      t_rstart(1'b1);
      do_reset();
      t_start(1'b0, 1'b1);
      final_report();
   end
endmodule
